//--- common/nvm_cmd_pkg.sv
// Notes on behaviour
// - read value register holds byte of last triggered read, not default-load bytes, resets zero
// - busy flag bit 3 while read engine runs
// - trigger bit 2 starts read; poll busy, read result
// - command bit 7 starts one supply measurement
// - command bit 6 preloads next result into registers
// - command bit 5 clears all charge counters
// - command bit 4 starts charge counter calibration
// - command bit 2 reloads defaults from memory
// - command bit 0 forces full device reset
// - full reset clears registers, then reloads defaults
// - outputs held off until load, at most 400us; two cycles only if full reset meets a running or starting load
// - defaults reload keeps enabled converters running
package nvm_cmd_pkg;

  localparam int NVM_AW = 7;
  localparam int NVM_DW = 8;
  localparam int IDX_W  = 6;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_NVM_ADDRESS        = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_NVM_READ_VALUE     = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_NVM_STATUS_CONTROL = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_COMMAND_STROBES    = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS         = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK           = 6'h21;

  // field positions
  localparam int NVM_BUSY_BIT           = 3;
  localparam int NVM_TRIGGER_BIT        = 2;
  localparam int CMD_MEASURE_START_BIT  = 7;
  localparam int CMD_RESULT_PRELOAD_BIT = 6;
  localparam int CMD_CHARGE_CLEAR_BIT   = 5;
  localparam int CMD_CHARGE_CAL_BIT     = 4;
  localparam int CMD_DEFAULTS_RELOAD_BIT = 2;
  localparam int CMD_FULL_RESET_BIT     = 0;

  localparam int IRQ_W              = 3;
  localparam int IRQ_READ_DONE_BIT  = 0;
  localparam int IRQ_LOAD_DONE_BIT  = 1;
  localparam int IRQ_PRELOAD_BIT    = 2;

  // reset values
  localparam logic [NVM_DW-1:0] RESET_BYTE = 8'h00;
  localparam logic [NVM_AW-1:0] RESET_ADDR = 7'h00;
  localparam logic [IRQ_W-1:0]  RESET_IRQ  = 3'h0;

  // timing
  localparam int CLOCK_KHZ       = 10000;
  localparam int LOAD_MAX_US     = 400;
  localparam int LOAD_MAX_CYCLES = (LOAD_MAX_US * CLOCK_KHZ) / 1000;
  localparam int DEFAULT_COUNT   = 16;

  typedef struct packed {
    logic              valid;
    logic [NVM_AW-1:0] addr;
    logic [NVM_DW-1:0] data;
  } default_write_s;

endpackage : nvm_cmd_pkg

//--- rtl/nvm_fetch.sv
`timescale 1ns/1ps
// single-location read engine of the configuration memory
module nvm_fetch #(
  parameter int AW = nvm_cmd_pkg::NVM_AW,
  parameter int DW = nvm_cmd_pkg::NVM_DW
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_b,
  input  wire logic          i_start,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic          i_mem_valid,
  input  wire logic [DW-1:0] i_mem_data,
  output logic               o_mem_rd,
  output logic [AW-1:0]      o_mem_addr,
  output logic               o_busy,
  output logic               o_done,
  output logic [DW-1:0]      o_data
);

  typedef enum logic [0:0] {FETCH_IDLE, FETCH_WAIT} fetch_state_e;

  fetch_state_e state_q;
  wire logic    take;
  wire logic    finish;

  if (AW < 1 || DW < 1) begin : g_bad_width
    $error("nvm_fetch: widths must be positive");
  end

  assign take   = (state_q == FETCH_IDLE) && i_start;
  assign finish = (state_q == FETCH_WAIT) && i_mem_valid;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_q    <= FETCH_IDLE;
      o_mem_rd   <= 1'b0;
      o_mem_addr <= '0;
      o_busy     <= 1'b0;
      o_done     <= 1'b0;
      o_data     <= '0;
    end else begin
      o_mem_rd <= take;
      o_done   <= finish;
      if (take) begin
        state_q    <= FETCH_WAIT;
        o_mem_addr <= i_addr;
        o_busy     <= 1'b1;
      end
      if (finish) begin
        state_q <= FETCH_IDLE;
        o_busy  <= 1'b0;
        o_data  <= i_mem_data;
      end
    end
  end

endmodule : nvm_fetch

//--- rtl/defaults_loader.sv
`timescale 1ns/1ps
// walks the default locations of the memory and emits control register writes
module defaults_loader #(
  parameter int COUNT      = nvm_cmd_pkg::DEFAULT_COUNT,
  parameter int MAX_CYCLES = nvm_cmd_pkg::LOAD_MAX_CYCLES
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_rst_b,
  input  wire logic                        i_start,
  input  wire logic                        i_hold,
  input  wire logic                        i_fetch_busy,
  input  wire logic                        i_fetch_done,
  input  wire logic [nvm_cmd_pkg::NVM_DW-1:0] i_fetch_data,
  output logic                             o_fetch_start,
  output logic [nvm_cmd_pkg::NVM_AW-1:0]   o_fetch_addr,
  output nvm_cmd_pkg::default_write_s      o_write,
  output logic                             o_hold,
  output logic                             o_busy,
  output logic                             o_done
);

  localparam int TW = $clog2(MAX_CYCLES + 1);

  typedef enum logic [1:0] {LOAD_IDLE, LOAD_ISSUE, LOAD_WAIT} load_state_e;

  load_state_e                      state_q;
  logic [nvm_cmd_pkg::NVM_AW-1:0]   idx_q;
  logic [TW-1:0]                    timer_q;
  wire logic                        last;
  wire logic                        expired;
  wire logic                        finish;

  if (COUNT < 1 || COUNT > (1 << nvm_cmd_pkg::NVM_AW)) begin : g_bad_count
    $error("defaults_loader: bad COUNT");
  end
  if (MAX_CYCLES < 1) begin : g_bad_cycles
    $error("defaults_loader: bad MAX_CYCLES");
  end

  assign last    = (idx_q == nvm_cmd_pkg::NVM_AW'(COUNT - 1));
  assign expired = (timer_q == TW'(MAX_CYCLES - 1));
  assign finish  = (state_q != LOAD_IDLE) && (expired || (state_q == LOAD_WAIT && i_fetch_done && last));

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_q       <= LOAD_IDLE;
      idx_q         <= '0;
      timer_q       <= '0;
      o_fetch_start <= 1'b0;
      o_fetch_addr  <= '0;
      o_write       <= '0;
      o_hold        <= 1'b0;
      o_busy        <= 1'b0;
      o_done        <= 1'b0;
    end else begin
      o_fetch_start <= 1'b0;
      o_write.valid <= 1'b0;
      o_done        <= finish;
      unique case (state_q)
        LOAD_IDLE: begin
          if (i_start) begin
            state_q <= LOAD_ISSUE;
            idx_q   <= '0;
            timer_q <= '0;
            o_busy  <= 1'b1;
            o_hold  <= i_hold;
          end
        end
        LOAD_ISSUE: begin
          timer_q <= timer_q + 1'b1;
          if (!i_fetch_busy) begin
            o_fetch_start <= 1'b1;
            o_fetch_addr  <= idx_q;
            state_q       <= LOAD_WAIT;
          end
        end
        LOAD_WAIT: begin
          timer_q <= timer_q + 1'b1;
          if (i_fetch_done) begin
            o_write <= '{valid: 1'b1, addr: idx_q, data: i_fetch_data};
            idx_q   <= idx_q + 1'b1;
            state_q <= LOAD_ISSUE;
          end
        end
      endcase
      if (finish) begin
        state_q <= LOAD_IDLE;
        o_busy  <= 1'b0;
        o_hold  <= 1'b0;
      end
    end
  end

endmodule : defaults_loader

//--- rtl/nvm_command_regs.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// memory readback and command strobe register bank on APB
module nvm_command_regs #(
  parameter int DEFAULT_COUNT = nvm_cmd_pkg::DEFAULT_COUNT,
  parameter int LOAD_CYCLES   = nvm_cmd_pkg::LOAD_MAX_CYCLES
) (
  input  wire logic                           i_clock,
  input  wire logic                           i_rst_b,
  input  wire logic                           i_psel,
  input  wire logic                           i_penable,
  input  wire logic                           i_pwrite,
  input  wire logic [7:0]                     i_paddr,
  input  wire logic [31:0]                    i_pwdata,
  output logic [31:0]                         o_prdata,
  output logic                                o_pready,
  output logic                                o_pslverr,
  input  wire logic                           i_nvm_valid,
  input  wire logic [nvm_cmd_pkg::NVM_DW-1:0] i_nvm_data,
  output logic                                o_nvm_rd,
  output logic [nvm_cmd_pkg::NVM_AW-1:0]      o_nvm_addr,
  input  wire logic                           i_conversion_done,
  output logic                                o_measure_start,
  output logic                                o_result_preload,
  output logic                                o_charge_count_clear,
  output logic                                o_charge_cal_start,
  output logic                                o_regs_clear,
  output nvm_cmd_pkg::default_write_s         o_default_write,
  output logic                                o_outputs_hold,
  output logic                                o_load_busy,
  output logic                                o_irq
);

  localparam int AW = nvm_cmd_pkg::NVM_AW;
  localparam int DW = nvm_cmd_pkg::NVM_DW;
  localparam int IW = nvm_cmd_pkg::IRQ_W;

  logic [AW-1:0] nvm_address_q;
  logic [DW-1:0] read_value_q;
  logic          trigger_q;
  logic          host_read_q;
  logic          preload_armed_q;
  logic [IW-1:0] irq_status_q;
  logic [IW-1:0] irq_mask_q;
  logic [IW-1:0] irq_status_d;

  wire logic [nvm_cmd_pkg::IDX_W-1:0] idx;
  wire logic          aligned;
  wire logic          hit_address;
  wire logic          hit_value;
  wire logic          hit_status_control;
  wire logic          hit_command;
  wire logic          hit_irq_status;
  wire logic          hit_irq_mask;
  wire logic          mapped;
  wire logic          access;
  wire logic          fire;
  wire logic          wr_fire;
  wire logic          rd_fire;
  wire logic [7:0]    wbyte;
  wire logic          cmd_wr;
  wire logic          full_reset;
  wire logic          reload;
  wire logic [7:0]    status_control_view;
  wire logic [31:0]   read_mux;
  wire logic [IW-1:0] irq_events;
  wire logic [IW-1:0] irq_clear;

  wire logic          fetch_start;
  wire logic [AW-1:0] fetch_addr;
  wire logic          fetch_busy;
  wire logic          fetch_done;
  wire logic [DW-1:0] fetch_data;
  wire logic          host_start;
  wire logic          load_start;
  wire logic          load_fetch_start;
  wire logic [AW-1:0] load_fetch_addr;
  wire logic          load_busy;
  wire logic          load_done;
  wire logic          load_hold;
  wire logic          host_done;

  // address decode: one aligned word per register index
  assign idx                = i_paddr[7:2];
  assign aligned            = (i_paddr[1:0] == 2'h0);
  assign hit_address        = aligned && (idx == nvm_cmd_pkg::IDX_NVM_ADDRESS);
  assign hit_value          = aligned && (idx == nvm_cmd_pkg::IDX_NVM_READ_VALUE);
  assign hit_status_control = aligned && (idx == nvm_cmd_pkg::IDX_NVM_STATUS_CONTROL);
  assign hit_command        = aligned && (idx == nvm_cmd_pkg::IDX_COMMAND_STROBES);
  assign hit_irq_status     = aligned && (idx == nvm_cmd_pkg::IDX_IRQ_STATUS);
  assign hit_irq_mask       = aligned && (idx == nvm_cmd_pkg::IDX_IRQ_MASK);
  assign mapped             = hit_address || hit_value || hit_status_control || hit_command
                              || hit_irq_status || hit_irq_mask;

  // one wait state: request taken at the edge where pready is already high
  assign access  = i_psel && i_penable && !o_pready;
  assign fire    = i_psel && i_penable && o_pready;
  assign wr_fire = fire && i_pwrite && mapped;
  assign rd_fire = fire && !i_pwrite && mapped;
  assign wbyte   = i_pwdata[7:0];

  assign cmd_wr     = wr_fire && hit_command;
  assign full_reset = cmd_wr && wbyte[nvm_cmd_pkg::CMD_FULL_RESET_BIT];
  assign reload     = cmd_wr && wbyte[nvm_cmd_pkg::CMD_DEFAULTS_RELOAD_BIT];

  // reserved bits read as zero; busy covers pending and running reads
  assign status_control_view = {4'h0, trigger_q || host_read_q, trigger_q, 2'h0};

  assign read_mux = hit_address        ? {25'h0, nvm_address_q} :
                    hit_value          ? {24'h0, read_value_q} :
                    hit_status_control ? {24'h0, status_control_view} :
                    hit_irq_status     ? {29'h0, irq_status_q} :
                    hit_irq_mask       ? {29'h0, irq_mask_q} :
                    32'h0000_0000;

  // memory port arbitration: the default load owns it while it runs
  assign host_start  = trigger_q && !fetch_busy && !load_busy && !host_read_q;
  assign load_start  = (reload && !load_busy) || o_regs_clear;
  assign fetch_start = load_busy ? load_fetch_start : host_start;
  assign fetch_addr  = load_busy ? load_fetch_addr : nvm_address_q;
  assign host_done   = fetch_done && host_read_q;

  assign irq_events[nvm_cmd_pkg::IRQ_READ_DONE_BIT] = host_done;
  assign irq_events[nvm_cmd_pkg::IRQ_LOAD_DONE_BIT] = load_done;
  assign irq_events[nvm_cmd_pkg::IRQ_PRELOAD_BIT]   = preload_armed_q && i_conversion_done;
  assign irq_clear    = (rd_fire && hit_irq_status) ? {IW{1'b1}} : {IW{1'b0}};
  assign irq_status_d = (irq_status_q & ~irq_clear) | irq_events;  // set wins over clear

  nvm_fetch #(
    .AW (AW),
    .DW (DW)
  ) u_fetch (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_start     (fetch_start),
    .i_addr      (fetch_addr),
    .i_mem_valid (i_nvm_valid),
    .i_mem_data  (i_nvm_data),
    .o_mem_rd    (o_nvm_rd),
    .o_mem_addr  (o_nvm_addr),
    .o_busy      (fetch_busy),
    .o_done      (fetch_done),
    .o_data      (fetch_data)
  );

  defaults_loader #(
    .COUNT      (DEFAULT_COUNT),
    .MAX_CYCLES (LOAD_CYCLES)
  ) u_loader (
    .i_clock       (i_clock),
    .i_rst_b       (i_rst_b),
    .i_start       (load_start),
    .i_hold        (o_regs_clear),
    .i_fetch_busy  (fetch_busy),
    .i_fetch_done  (fetch_done),
    .i_fetch_data  (fetch_data),
    .o_fetch_start (load_fetch_start),
    .o_fetch_addr  (load_fetch_addr),
    .o_write       (o_default_write),
    .o_hold        (load_hold),
    .o_busy        (load_busy),
    .o_done        (load_done)
  );

  // bus answer
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= access;
      o_pslverr <= access && !mapped;
      o_prdata  <= (access && !i_pwrite) ? read_mux : 32'h0000_0000;
    end
  end

  // one-cycle command strobes
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_measure_start      <= 1'b0;
      o_charge_count_clear <= 1'b0;
      o_charge_cal_start   <= 1'b0;
      o_regs_clear         <= 1'b0;
    end else begin
      o_measure_start      <= cmd_wr && wbyte[nvm_cmd_pkg::CMD_MEASURE_START_BIT];
      o_charge_count_clear <= cmd_wr && wbyte[nvm_cmd_pkg::CMD_CHARGE_CLEAR_BIT];
      o_charge_cal_start   <= cmd_wr && wbyte[nvm_cmd_pkg::CMD_CHARGE_CAL_BIT];
      o_regs_clear         <= full_reset;
    end
  end

  // readback registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_b || full_reset) begin
      nvm_address_q <= nvm_cmd_pkg::RESET_ADDR;
      read_value_q  <= nvm_cmd_pkg::RESET_BYTE;
      trigger_q     <= 1'b0;
      host_read_q   <= 1'b0;
    end else begin
      if (wr_fire && hit_address) begin
        nvm_address_q <= wbyte[AW-1:0];
      end
      if (wr_fire && hit_status_control && wbyte[nvm_cmd_pkg::NVM_TRIGGER_BIT]) begin
        trigger_q <= 1'b1;
      end else if (host_start) begin
        trigger_q <= 1'b0;
      end
      if (host_start) begin
        host_read_q <= 1'b1;
      end else if (host_done) begin
        host_read_q <= 1'b0;
      end
      if (host_done) begin
        read_value_q <= fetch_data;
      end
    end
  end

  // measurement preload, interrupt status and mask
  always_ff @(posedge i_clock) begin
    if (!i_rst_b || full_reset) begin
      preload_armed_q <= 1'b0;
      irq_status_q    <= nvm_cmd_pkg::RESET_IRQ;
      irq_mask_q      <= nvm_cmd_pkg::RESET_IRQ;
    end else begin
      if (cmd_wr && wbyte[nvm_cmd_pkg::CMD_RESULT_PRELOAD_BIT]) begin
        preload_armed_q <= 1'b1;
      end else if (i_conversion_done) begin
        preload_armed_q <= 1'b0;
      end
      irq_status_q <= irq_status_d;
      if (wr_fire && hit_irq_mask) begin
        irq_mask_q <= wbyte[IW-1:0];
      end
    end
  end

  // outputs toward the analog side
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_result_preload <= 1'b0;
      o_outputs_hold   <= 1'b0;
      o_load_busy      <= 1'b0;
      o_irq            <= 1'b0;
    end else begin
      o_result_preload <= preload_armed_q && !full_reset;
      o_outputs_hold   <= full_reset || o_regs_clear || load_hold;
      o_load_busy      <= load_busy || load_start;
      o_irq            <= |(irq_status_d & irq_mask_q);
    end
  end

endmodule : nvm_command_regs

//--- verification/nvm_command_regs_chk.sv
`timescale 1ns/1ps
// timing checks on the command strobes, preload arming and the defaults load
module nvm_command_regs_chk #(
  parameter int LOAD_CYCLES = 50
) (
  input wire logic                        i_clock,
  input wire logic                        i_rst_b,
  input wire logic                        i_psel,
  input wire logic                        i_penable,
  input wire logic                        i_pwrite,
  input wire logic [7:0]                  i_paddr,
  input wire logic [31:0]                 i_pwdata,
  input wire logic [31:0]                 o_prdata,
  input wire logic                        o_pready,
  input wire logic                        o_pslverr,
  input wire logic                        i_nvm_valid,
  input wire logic                        o_nvm_rd,
  input wire logic                        i_conversion_done,
  input wire logic                        o_measure_start,
  input wire logic                        o_result_preload,
  input wire logic                        o_charge_count_clear,
  input wire logic                        o_charge_cal_start,
  input wire logic                        o_regs_clear,
  input wire nvm_cmd_pkg::default_write_s o_default_write,
  input wire logic                        o_outputs_hold,
  input wire logic                        o_load_busy
);
  wire [7:0]  cmd_addr = {nvm_cmd_pkg::IDX_COMMAND_STROBES, 2'b00};
  wire        take     = i_psel && i_penable && o_pready && !o_pslverr && (i_paddr == cmd_addr);
  wire        cmd_wr   = take && i_pwrite;
  wire [15:0] hold_cnt_d;
  logic [15:0] hold_cnt_q;
  assign hold_cnt_d = o_outputs_hold ? hold_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) hold_cnt_q <= 16'h0000;
    else hold_cnt_q <= hold_cnt_d;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  a_measure_strobe: assert property (o_measure_start == $past(cmd_wr && i_pwdata[7]))
    else $error("measure start does not follow command write");
  a_charge_clear: assert property (o_charge_count_clear == $past(cmd_wr && i_pwdata[5]))
    else $error("charge clear does not follow command write");
  a_charge_cal: assert property (o_charge_cal_start == $past(cmd_wr && i_pwdata[4]))
    else $error("calibration start does not follow command write");
  a_full_reset: assert property (o_regs_clear == $past(cmd_wr && i_pwdata[0]))
    else $error("register clear does not follow command write");
  a_preload_arm: assert property (cmd_wr && i_pwdata[6] && !i_pwdata[0] |-> ##2 o_result_preload)
    else $error("preload not armed");
  a_preload_drop: assert property (o_result_preload && i_conversion_done && !(cmd_wr && i_pwdata[6])
    |-> ##2 !o_result_preload)
    else $error("preload outlived conversion");
  a_clear_holds: assert property ($rose(o_regs_clear) |-> ##[0:2] o_outputs_hold)
    else $error("outputs not held after full reset");
  a_hold_bound: assert property (hold_cnt_q <= LOAD_CYCLES + 4)
    else $error("outputs held too long");
  a_reload_nohold: assert property (cmd_wr && i_pwdata[2] && !i_pwdata[0] && !o_outputs_hold
    |=> !o_outputs_hold [*4])
    else $error("reload held outputs");
  a_reload_start: assert property (cmd_wr && i_pwdata[2] && !i_pwdata[0] && !o_load_busy
    |-> ##[1:3] o_load_busy)
    else $error("reload did not start a load");
  a_cmd_reads0: assert property (take && !i_pwrite |-> o_prdata == 32'h0000_0000)
    else $error("command register read not zero");
  a_default_src: assert property (o_default_write.valid |-> $past(i_nvm_valid, 2))
    else $error("default write without memory answer");
  a_read_pulse: assert property (o_nvm_rd |=> !o_nvm_rd)
    else $error("memory read request longer than one cycle");
endmodule : nvm_command_regs_chk

//--- verification/nvm_command_regs_tb.sv
`timescale 1ns/1ps
module nvm_command_regs_tb;
  localparam int CNT = 4;
  localparam int LOADC = 200;
  localparam logic [7:0] adr_addr = {nvm_cmd_pkg::IDX_NVM_ADDRESS, 2'b00};
  localparam logic [7:0] adr_val  = {nvm_cmd_pkg::IDX_NVM_READ_VALUE, 2'b00};
  localparam logic [7:0] adr_stat = {nvm_cmd_pkg::IDX_NVM_STATUS_CONTROL, 2'b00};
  localparam logic [7:0] adr_cmd  = {nvm_cmd_pkg::IDX_COMMAND_STROBES, 2'b00};
  localparam logic [7:0] adr_irqs = {nvm_cmd_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] adr_irqm = {nvm_cmd_pkg::IDX_IRQ_MASK, 2'b00};
  logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, nvm_data = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, nvm_valid = 1'b0, nvm_rd, conv_done = 1'b0, meas, preload, cclr, ccal, rclr;
  logic [6:0] nvm_addr, mem_a = 7'h00;
  nvm_cmd_pkg::default_write_s dw, last_dw;
  logic hold, lbusy, irq, hold_seen = 1'b0;
  int fail_count = 0, num_checks = 0, mem_cnt = 0;
  int c_meas = 0, c_clr = 0, c_cal = 0, c_rst = 0, c_dw = 0;
  nvm_command_regs #(.DEFAULT_COUNT(CNT), .LOAD_CYCLES(LOADC)) dut_u (
    .i_clock(clock), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_nvm_valid(nvm_valid), .i_nvm_data(nvm_data), .o_nvm_rd(nvm_rd), .o_nvm_addr(nvm_addr),
    .i_conversion_done(conv_done), .o_measure_start(meas), .o_result_preload(preload),
    .o_charge_count_clear(cclr), .o_charge_cal_start(ccal), .o_regs_clear(rclr),
    .o_default_write(dw), .o_outputs_hold(hold), .o_load_busy(lbusy), .o_irq(irq));
  initial begin
    forever #50 clock = ~clock;
  end
  function automatic logic [7:0] mem_byte(input logic [6:0] a);
    return {1'b1, a} ^ 8'h3C;
  endfunction : mem_byte
  // memory answers ten cycles after a request; the data line toggles when idle
  always @(posedge clock) begin
    if (mem_cnt == 1) nvm_data <= mem_byte(mem_a);
    else nvm_data <= ~nvm_data;
    nvm_valid <= (mem_cnt == 1);
    if (nvm_rd) mem_cnt <= 10;
    else if (mem_cnt != 0) mem_cnt <= mem_cnt - 1;
    if (nvm_rd) mem_a <= nvm_addr;
  end
  always @(posedge clock) begin
    c_meas += meas;
    c_clr += cclr;
    c_cal += ccal;
    c_rst += rclr;
    if (dw.valid === 1'b1) c_dw++;
    if (dw.valid === 1'b1) last_dw = dw;
    if (hold === 1'b1) hold_seen = 1'b1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rd_chk
  task automatic t_reset_vals;
    rd_chk(adr_val, 32'h0);
    rd_chk(adr_stat, 32'h0);
    rd_chk(adr_cmd, 32'h0);
    rd_chk(adr_irqs, 32'h0);
  endtask : t_reset_vals
  task automatic t_read;
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    wr(adr_irqm, 8'h00);
    wr(adr_addr, 8'h15);
    rd_chk(adr_addr, 32'h15);
    wr(adr_stat, 8'h04);
    apb(1'b0, adr_stat, 32'h0, r, e);
    check(r & 32'h8, 32'h8);
    do begin
      apb(1'b0, adr_stat, 32'h0, r, e);
      n++;
    end while (r[3] !== 1'b0 && n < 30);
    check(r & 32'h8, 32'h0);
    check(nvm_addr, 32'h15);
    rd_chk(adr_val, mem_byte(7'h15));
    check(irq, 1'b0);
    wr(adr_irqm, 8'h07);
    repeat (2) @(posedge clock);
    check(irq, 1'b1);
    rd_chk(adr_irqs, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    wr(adr_val, 8'hFF);
    rd_chk(adr_val, mem_byte(7'h15));
    apb(1'b0, 8'h3C, 32'h0, r, e);
    check(e, 1'b1);
    check(r, 32'h0);
    apb(1'b1, 8'h41, 32'h80, r, e);
    check(e, 1'b1);
  endtask : t_read
  task automatic t_strobes;
    int m, c, k;
    m = c_meas;
    c = c_clr;
    k = c_cal;
    wr(adr_cmd, 8'h80);
    wr(adr_cmd, 8'h30);
    repeat (3) @(posedge clock);
    check(c_meas - m, 1);
    check(c_clr - c, 1);
    check(c_cal - k, 1);
    rd_chk(adr_cmd, 32'h0);
  endtask : t_strobes
  task automatic t_preload;
    wr(adr_cmd, 8'h40);
    repeat (5) @(posedge clock);
    check(preload, 1'b1);
    conv_done <= 1'b1;
    @(posedge clock);
    conv_done <= 1'b0;
    repeat (2) @(posedge clock);
    check(preload, 1'b0);
  endtask : t_preload
  task automatic t_load(input logic full);
    logic [31:0] r;
    logic e;
    int n, d, q;
    n = 0;
    d = c_dw;
    q = c_rst;
    wr(adr_addr, 8'h2A);
    hold_seen = 1'b0;
    wr(adr_cmd, full ? 8'h01 : 8'h04);
    repeat (3) @(posedge clock);
    while (lbusy !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    repeat (3) @(posedge clock);
    check(c_dw - d, CNT);
    check(last_dw, {1'b1, 7'(CNT - 1), mem_byte(7'(CNT - 1))});
    check(hold_seen, full);
    check(hold, 1'b0);
    check(c_rst - q, full);
    if (full) rd_chk(adr_addr, 32'h0);
    apb(1'b0, adr_irqs, 32'h0, r, e);
    check(r & 32'h2, 32'h2);
  endtask : t_load
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    t_reset_vals();
    t_read();
    t_strobes();
    t_preload();
    t_load(1'b0);
    t_load(1'b1);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end
endmodule : nvm_command_regs_tb
bind nvm_command_regs nvm_command_regs_chk #(.LOAD_CYCLES(LOAD_CYCLES)) chk_u (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_nvm_valid(i_nvm_valid), .o_nvm_rd(o_nvm_rd), .i_conversion_done(i_conversion_done),
  .o_measure_start(o_measure_start), .o_result_preload(o_result_preload),
  .o_charge_count_clear(o_charge_count_clear), .o_charge_cal_start(o_charge_cal_start),
  .o_regs_clear(o_regs_clear), .o_default_write(o_default_write), .o_outputs_hold(o_outputs_hold),
  .o_load_busy(o_load_busy));
